// ### core/uif_ctrl.sv
/*
 uif_ctrl: interrupt enable, prioritised interrupt source, fifo control
 and line format of one uart channel, with receive fifo and skid buffer.
 assumes host strobes rd or wr for one clock per access, all synchronous.
*/
`timescale 1ns/1ps
module uif_ctrl (
    // clock and reset
    input  logic                i_clk,
    input  logic                i_srst,
    // host register bus
    input  uif_pkg::uif_bus_s   i_bus,
    output logic [7:0]          o_rdata,
    // receiver side
    input  logic                i_rx_valid,
    input  uif_pkg::uif_char_s  i_rx_char,
    output logic                o_rx_ready,
    // transmitter side
    input  logic                i_tx_take,
    input  logic                i_tsr_empty,
    input  logic                i_txd_raw,
    input  logic                i_bit_tick,
    output logic [4:0]          o_tx_level,
    output logic                o_txd,
    output uif_pkg::uif_fmt_s   o_fmt,
    output logic [15:0]         o_divisor,
    // modem status and pins
    input  logic [7:0]          i_msr,
    output logic                o_msr_rd,
    output logic                o_irq,
    output logic                o_transmit_ready_pin_n,
    output logic                o_receive_ready_pin_n
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] trig_lvl(input logic [1:0] t);
        case (t)
            2'h0:    trig_lvl = uif_pkg::TRIG_1;
            2'h1:    trig_lvl = uif_pkg::TRIG_4;
            2'h2:    trig_lvl = uif_pkg::TRIG_8;
            default: trig_lvl = uif_pkg::TRIG_14;
        endcase
    endfunction : trig_lvl

    function automatic logic [3:0] src_code(input logic [4:0] p);
        if (p[4]) begin
            src_code = uif_pkg::ID_LSR;
        end else if (p[3]) begin
            src_code = uif_pkg::ID_TMO;
        end else if (p[2]) begin
            src_code = uif_pkg::ID_RXD;
        end else if (p[1]) begin
            src_code = uif_pkg::ID_TXR;
        end else if (p[0]) begin
            src_code = uif_pkg::ID_MSR;
        end else begin
            src_code = uif_pkg::ID_NONE;
        end
    endfunction : src_code

    function automatic logic has_err(input uif_pkg::uif_char_s c);
        has_err = c.brk | c.ferr | c.perr;
    endfunction : has_err

    // 1.5 stop bits round up to 2 here; time-out is a bound, not exact
    function automatic logic [7:0] char_bits(input logic [7:0] l);
        char_bits = 8'h06 + {6'h00, l[1:0]} + {7'h00, l[3]}
                  + (l[2] ? 8'h02 : 8'h01);
    endfunction : char_bits

    function automatic uif_pkg::uif_fmt_s fmt_of(input logic [7:0] l);
        fmt_of.wl        = l[1:0];
        fmt_of.stop_half = !l[2] ? uif_pkg::HALF_1 :
                           (l[1:0] == 2'h0) ? uif_pkg::HALF_15 : uif_pkg::HALF_2;
        fmt_of.par_en    = l[3];
        fmt_of.par_even  = l[4];
        fmt_of.par_force = l[5];
        fmt_of.par_val   = !l[4];
        fmt_of.brk       = l[6];
    endfunction : fmt_of

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    uif_pkg::uif_state_s s;
    uif_pkg::uif_state_s n;
    logic                dlab;
    logic                rd_rhr;
    logic                rd_isr;
    logic                rd_lsr;
    logic                rd_msr;
    logic                wr_thr;
    logic                wr_fcr;
    logic                push;
    logic                pop;
    logic                accept;
    logic                ovr_ev;
    logic                rst_rx;
    logic                rst_tx;
    logic                head_new;
    logic [4:0]          cap;
    logic [4:0]          pend;
    logic [3:0]          src;
    logic [7:0]          lsr_val;
    logic [7:0]          rd_val;
    logic [7:0]          tmo_lim;
    logic [1:0]          wslot;
    uif_pkg::uif_char_s  head;
    uif_pkg::uif_char_s  nhead;

    always_comb begin
        n = s;
        dlab = s.line_format[uif_pkg::LC_DLAB];
        rd_rhr = 1'b0;
        rd_isr = 1'b0;
        rd_lsr = 1'b0;
        rd_msr = 1'b0;
        wr_thr = 1'b0;
        wr_fcr = 1'b0;
        head = s.mem[s.rd_ptr];
        cap = s.fcr_en ? uif_pkg::DEPTH : 5'h01;

        // address decode, divisor latch overlay
        if (i_bus.addr == uif_pkg::A_DATA) begin
            rd_rhr = i_bus.rd && !dlab;
            wr_thr = i_bus.wr && !dlab;
            if (i_bus.wr && dlab) begin
                n.dll = i_bus.wdata;
            end
        end else if (i_bus.addr == uif_pkg::A_IER) begin
            if (i_bus.wr && dlab) begin
                n.divisor_high = i_bus.wdata;
            end else if (i_bus.wr) begin
                n.interrupt_enable = i_bus.wdata[3:0];
            end
        end else if (i_bus.addr == uif_pkg::A_ISR) begin
            rd_isr = i_bus.rd;
            wr_fcr = i_bus.wr;
        end else if (i_bus.addr == uif_pkg::A_LCR) begin
            if (i_bus.wr) begin
                n.line_format = i_bus.wdata;
            end
        end else if (i_bus.addr == uif_pkg::A_LSR) begin
            rd_lsr = i_bus.rd;
        end else if (i_bus.addr == uif_pkg::A_MSR) begin
            rd_msr = i_bus.rd;
        end

        // queue control; reset bits are actions, never stored
        rst_rx = 1'b0;
        rst_tx = 1'b0;
        if (wr_fcr) begin
            n.fcr_en = i_bus.wdata[uif_pkg::FC_EN];
            // mode change flushes both queues so depth never exceeds cap
            rst_rx = i_bus.wdata[0] != s.fcr_en;
            rst_tx = i_bus.wdata[0] != s.fcr_en;
            if (i_bus.wdata[uif_pkg::FC_EN]) begin
                n.dma  = i_bus.wdata[uif_pkg::FC_DMA];
                n.trig = i_bus.wdata[7:6];
                rst_rx = rst_rx | i_bus.wdata[uif_pkg::FC_RXRST];
                rst_tx = rst_tx | i_bus.wdata[uif_pkg::FC_TXRST];
            end
        end

        // skid buffer between shifter and fifo
        accept = i_rx_valid && s.rx_ready;
        ovr_ev = i_rx_valid && !s.rx_ready;
        pop    = rd_rhr && (s.rx_cnt != 5'h00);
        push   = (s.skid_cnt != 2'h0) && (s.rx_cnt < cap) && !rst_rx;
        wslot  = s.skid_cnt - {1'b0, push};
        if (push) begin
            n.skid[0] = s.skid[1];
        end
        if (accept) begin
            n.skid[wslot[0]] = i_rx_char;
        end
        n.skid_cnt = wslot + {1'b0, accept};
        n.rx_ready = n.skid_cnt != 2'h2;

        // receive fifo
        if (push) begin
            n.mem[s.wr_ptr] = s.skid[0];
            n.wr_ptr = s.wr_ptr + 4'h1;
        end
        if (pop) begin
            n.rd_ptr = s.rd_ptr + 4'h1;
        end
        n.rx_cnt  = s.rx_cnt + {4'h0, push} - {4'h0, pop};
        n.err_cnt = s.err_cnt + {4'h0, push && has_err(s.skid[0]) }
                  - {4'h0, pop && has_err(head)};
        if (rst_rx) begin
            n.rd_ptr  = 4'h0;
            n.wr_ptr  = 4'h0;
            n.rx_cnt  = 5'h00;
            n.err_cnt = 5'h00;
        end
        nhead    = n.mem[n.rd_ptr];
        head_new = (pop || s.rx_cnt == 5'h00) && n.rx_cnt != 5'h00;

        // transmit fifo level
        n.tx_cnt = s.tx_cnt + {4'h0, wr_thr && s.tx_cnt < cap}
                 - {4'h0, i_tx_take && s.tx_cnt != 5'h00};
        if (rst_tx) begin
            n.tx_cnt = 5'h00;
        end

        // line status flags; a new event beats the read clear
        if (rd_lsr) begin
            n.ovr     = 1'b0;
            n.lsr_int = 1'b0;
        end
        if (ovr_ev) begin
            n.ovr     = 1'b1;
            n.lsr_int = 1'b1;
        end
        if (head_new && has_err(nhead)) begin
            n.lsr_int = 1'b1;
        end

        // character time-out
        tmo_lim = 8'(uif_pkg::TMO_CHARS * char_bits(s.line_format)) + uif_pkg::TMO_BITS;
        if (rd_rhr) begin
            n.tmo = 1'b0;
        end
        if (push || pop || s.rx_cnt == 5'h00 || !s.fcr_en) begin
            n.tmo_cnt = 8'h00;
        end else if (i_bit_tick && !s.tmo) begin
            n.tmo_cnt = s.tmo_cnt + 8'h01;
            n.tmo     = n.tmo_cnt == tmo_lim;
        end

        // pending sources, highest first
        pend[4] = s.interrupt_enable[uif_pkg::IE_LSR] && s.lsr_int;
        pend[3] = s.interrupt_enable[uif_pkg::IE_RXD] && s.tmo && s.fcr_en;
        pend[2] = s.interrupt_enable[uif_pkg::IE_RXD] && (s.fcr_en ?
                  s.rx_cnt >= trig_lvl(s.trig) : s.rx_cnt != 5'h00);
        pend[1] = s.interrupt_enable[uif_pkg::IE_TXR] && s.thr_int;
        pend[0] = s.interrupt_enable[uif_pkg::IE_MSR] && (i_msr[3:0] != 4'h0);
        src = src_code(pend);

        // transmit ready: set wins over a same-cycle clear
        if ((rd_isr && src == uif_pkg::ID_TXR) || wr_thr) begin
            n.thr_int = 1'b0;
        end
        if (n.interrupt_enable[uif_pkg::IE_TXR] && n.tx_cnt == 5'h00 &&
            (s.tx_cnt != 5'h00 || !s.interrupt_enable[uif_pkg::IE_TXR])) begin
            n.thr_int = 1'b1;
        end

        // read data
        lsr_val = {s.fcr_en && s.err_cnt != 5'h00,
                   s.tx_cnt == 5'h00 && i_tsr_empty,
                   s.tx_cnt == 5'h00,
                   s.rx_cnt != 5'h00 && head.brk,
                   s.rx_cnt != 5'h00 && head.ferr,
                   s.rx_cnt != 5'h00 && head.perr,
                   s.ovr,
                   s.rx_cnt != 5'h00};
        if (i_bus.addr == uif_pkg::A_DATA) begin
            rd_val = dlab ? s.dll : (s.rx_cnt != 5'h00 ? head.data : 8'h00);
        end else if (i_bus.addr == uif_pkg::A_IER) begin
            rd_val = dlab ? s.divisor_high : {4'h0, s.interrupt_enable};
        end else if (i_bus.addr == uif_pkg::A_ISR) begin
            rd_val = {s.fcr_en, s.fcr_en, 2'h0, src};
        end else if (i_bus.addr == uif_pkg::A_LCR) begin
            rd_val = s.line_format;
        end else if (i_bus.addr == uif_pkg::A_LSR) begin
            rd_val = lsr_val;
        end else if (i_bus.addr == uif_pkg::A_MSR) begin
            rd_val = i_msr;
        end else begin
            rd_val = 8'h00;
        end
        if (i_bus.rd) begin
            n.rdata = rd_val;
        end

        // pins and outputs
        n.msr_rd = rd_msr;
        n.irq    = pend != 5'h00;
        n.txd    = n.line_format[uif_pkg::LC_BRK] ? 1'b0 : i_txd_raw;
        n.fmt    = fmt_of(n.line_format);
        if (n.dma) begin
            n.receive_ready_pin_n = !(n.rx_cnt >= trig_lvl(n.trig) || n.tmo);
            n.transmit_ready_pin_n = n.tx_cnt >= cap;
        end else begin
            n.receive_ready_pin_n = n.rx_cnt == 5'h00;
            n.transmit_ready_pin_n = n.tx_cnt != 5'h00;
        end

        // synchronous reset: all enables off, line idle
        if (i_srst) begin
            n          = '0;
            n.interrupt_enable      = uif_pkg::RST_IER;
            n.line_format      = uif_pkg::RST_LCR;
            n.fmt      = fmt_of(uif_pkg::RST_LCR);
            n.rx_ready = 1'b1;
            n.receive_ready_pin_n  = 1'b1;
            n.txd      = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        s <= n;
    end

    assign o_rdata    = s.rdata;
    assign o_rx_ready = s.rx_ready;
    assign o_tx_level = s.tx_cnt;
    assign o_txd      = s.txd;
    assign o_fmt      = s.fmt;
    assign o_divisor  = {s.divisor_high, s.dll};
    assign o_msr_rd   = s.msr_rd;
    assign o_irq      = s.irq;
    assign o_transmit_ready_pin_n  = s.transmit_ready_pin_n;
    assign o_receive_ready_pin_n  = s.receive_ready_pin_n;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    rxd_nofifo_a: assert property (@(posedge i_clk) disable iff (i_srst)
        s.interrupt_enable[0] && !s.fcr_en && s.rx_cnt != 5'h00 |=> o_irq)
        else $error("receive data pending without irq");
    rxd_below_a: assert property (@(posedge i_clk) disable iff (i_srst)
        s.interrupt_enable == 4'h1 && s.fcr_en && !s.tmo && s.rx_cnt < trig_lvl(s.trig)
        |=> !o_irq) else $error("irq below trigger level");
    ready_set_a: assert property (@(posedge i_clk) disable iff (i_srst)
        push && !pop |=> s.rx_cnt != 5'h00) else $error("data ready not set");
    txe_bit_a: assert property (@(posedge i_clk) disable iff (i_srst)
        rd_lsr && s.tx_cnt == 5'h00 |=> o_rdata[5]) else $error("tx empty bit wrong");
    thr_rise_a: assert property (@(posedge i_clk) disable iff (i_srst)
        wr_fcr == 1'b0 && !s.interrupt_enable[1] && n.interrupt_enable[1] && s.tx_cnt == 5'h00 && !i_tx_take
        && !wr_thr |=> s.thr_int ##1 (o_irq || s.interrupt_enable[1] == 1'b0))
        else $error("tx ready not raised on enable");
    isr_top_a: assert property (@(posedge i_clk) disable iff (i_srst)
        rd_isr && pend[4] |=> o_rdata[3:0] == uif_pkg::ID_LSR)
        else $error("line status not reported first");
    tmo_clear_a: assert property (@(posedge i_clk) disable iff (i_srst)
        rd_rhr && s.rx_cnt != 5'h00 |=> !s.tmo) else $error("time-out not cleared");
    isr_none_a: assert property (@(posedge i_clk) disable iff (i_srst)
        rd_isr && pend == 5'h00 |=> o_rdata[0] && o_rdata[7:6] == {2{$past(s.fcr_en)}})
        else $error("no-pending code wrong");
    fcr_ignore_a: assert property (@(posedge i_clk) disable iff (i_srst)
        wr_fcr && !i_bus.wdata[0] |=> !s.fcr_en && s.trig == $past(s.trig))
        else $error("queue bits taken without enable");
    rx_reset_a: assert property (@(posedge i_clk) disable iff (i_srst)
        wr_fcr && i_bus.wdata[1:0] == 2'h3 |=> s.rx_cnt == 5'h00)
        else $error("receive queue not reset");
    // txd and lcr load on the same edge, so a clearing write must not trip this
    brk_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
        s.line_format[6] |-> !o_txd) else $error("break not driven");

endmodule : uif_ctrl

// ### core/uif_pkg.sv
/*
 uif_pkg: constants and carriers for the uart interrupt, fifo and line
 control block. assumes one 40 MHz clock domain and nothing else.
*/
package uif_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [2:0] A_DATA = 3'h0;
    localparam logic [2:0] A_IER  = 3'h1;
    localparam logic [2:0] A_ISR  = 3'h2;
    localparam logic [2:0] A_LCR  = 3'h3;
    localparam logic [2:0] A_LSR  = 3'h5;
    localparam logic [2:0] A_MSR  = 3'h6;
    // ------------------------------------------------------------
    // interrupt source codes
    // ------------------------------------------------------------
    localparam logic [3:0] ID_LSR  = 4'h6;
    localparam logic [3:0] ID_TMO  = 4'hc;
    localparam logic [3:0] ID_RXD  = 4'h4;
    localparam logic [3:0] ID_TXR  = 4'h2;
    localparam logic [3:0] ID_MSR  = 4'h0;
    localparam logic [3:0] ID_NONE = 4'h1;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int IE_RXD   = 0;
    localparam int IE_TXR   = 1;
    localparam int IE_LSR   = 2;
    localparam int IE_MSR   = 3;
    localparam int FC_EN    = 0;
    localparam int FC_RXRST = 1;
    localparam int FC_TXRST = 2;
    localparam int FC_DMA   = 3;
    localparam int LC_BRK   = 6;
    localparam int LC_DLAB  = 7;
    // ------------------------------------------------------------
    // sizes, levels, reset values, timing
    // ------------------------------------------------------------
    localparam logic [4:0] DEPTH     = 5'h10;
    localparam logic [4:0] TRIG_1    = 5'h01;
    localparam logic [4:0] TRIG_4    = 5'h04;
    localparam logic [4:0] TRIG_8    = 5'h08;
    localparam logic [4:0] TRIG_14   = 5'h0e;
    localparam logic [2:0] HALF_1    = 3'h2;
    localparam logic [2:0] HALF_15   = 3'h3;
    localparam logic [2:0] HALF_2    = 3'h4;
    localparam logic [7:0] TMO_CHARS = 8'h04;
    localparam logic [7:0] TMO_BITS  = 8'h0c;
    localparam logic [3:0] RST_IER   = 4'h0;
    localparam logic [7:0] RST_LCR   = 8'h00;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       brk;
        logic       ferr;
        logic       perr;
        logic [7:0] data;
    } uif_char_s;
    typedef struct packed {
        logic [2:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } uif_bus_s;
    typedef struct packed {
        logic [1:0] wl;
        logic [2:0] stop_half;
        logic       par_en;
        logic       par_even;
        logic       par_force;
        logic       par_val;
        logic       brk;
    } uif_fmt_s;
    typedef struct packed {
        logic [3:0]            interrupt_enable;
        logic [7:0]            line_format;
        logic                  fcr_en;
        logic                  dma;
        logic [1:0]            trig;
        logic [7:0]            dll;
        logic [7:0]            divisor_high;
        uif_char_s [15:0]      mem;
        logic [3:0]            rd_ptr;
        logic [3:0]            wr_ptr;
        logic [4:0]            rx_cnt;
        logic [4:0]            err_cnt;
        uif_char_s [1:0]       skid;
        logic [1:0]            skid_cnt;
        logic [4:0]            tx_cnt;
        logic                  ovr;
        logic                  lsr_int;
        logic                  tmo;
        logic [7:0]            tmo_cnt;
        logic                  thr_int;
        logic [7:0]            rdata;
        logic                  msr_rd;
        logic                  irq;
        logic                  txd;
        logic                  transmit_ready_pin_n;
        logic                  receive_ready_pin_n;
        logic                  rx_ready;
        uif_fmt_s              fmt;
    } uif_state_s;
endpackage : uif_pkg

// ### verification/test_uart_interrupt_fifo_line_control.sv
/*
 bench for uif_ctrl: register rows, then receive, transmit, modem cases.
 assumes uif_host as cpu and a 40 MHz clock.
*/
`timescale 1ns/1ps
module test_uart_interrupt_fifo_line_control;
    logic               i_clk = 1'b0;
    logic               i_srst = 1'b1;
    logic               rx_vld = 1'b0;
    uif_pkg::uif_char_s rx_chr = '0;
    logic               take = 1'b0;
    logic               tick = 1'b0;
    logic [7:0]         modem_status = 8'h00;
    logic               shift_idle = 1'b1;
    logic               ser_raw = 1'b1;
    logic               msr_rd;
    uif_pkg::uif_bus_s  bus;
    uif_pkg::uif_fmt_s  fmt;
    logic [7:0]         rdata;
    logic [7:0]         d;
    logic [4:0]         tx_lvl;
    logic [15:0]        div;
    logic               rx_rdy, irq, transmit_ready_pin_n, receive_ready_pin_n, txd;
    int                 error_cnt = 0;
    int                 n_checks = 0;
    // write addr, write data, read addr, expected read
    localparam logic [21:0] ROWS [8] = '{
        {uif_pkg::A_IER, 8'hff, uif_pkg::A_IER, 8'h0f},
        {uif_pkg::A_IER, 8'h00, uif_pkg::A_ISR, 8'h01},
        {uif_pkg::A_ISR, 8'h01, uif_pkg::A_ISR, 8'hc1},
        {uif_pkg::A_ISR, 8'h06, uif_pkg::A_ISR, 8'h01},
        {uif_pkg::A_LCR, 8'h3b, uif_pkg::A_LCR, 8'h3b},
        {uif_pkg::A_IER, 8'h02, uif_pkg::A_ISR, 8'h02},
        {uif_pkg::A_LCR, 8'h03, uif_pkg::A_ISR, 8'h01},
        {uif_pkg::A_IER, 8'h00, uif_pkg::A_LSR, 8'h60}};
    always #12.5 i_clk = ~i_clk;
    uif_host HOST (.i_clk(i_clk), .o_bus(bus), .i_rdata(rdata));
    uif_ctrl DUT (.i_clk(i_clk), .i_srst(i_srst), .i_bus(bus), .o_rdata(rdata),
        .i_rx_valid(rx_vld), .i_rx_char(rx_chr), .o_rx_ready(rx_rdy), .i_tx_take(take),
        .i_tsr_empty(shift_idle), .i_txd_raw(ser_raw), .i_bit_tick(tick), .o_tx_level(tx_lvl),
        .o_txd(txd), .o_fmt(fmt), .o_divisor(div), .i_msr(modem_status), .o_msr_rd(msr_rd),
        .o_irq(irq), .o_transmit_ready_pin_n(transmit_ready_pin_n), .o_receive_ready_pin_n(receive_ready_pin_n));
    task automatic results();
        if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        HOST.rd(a, d);
        chk(16'(d), 16'(exp));
    endtask : rchk
    task automatic wait_n(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : wait_n
    // a receiver with no room loses the char, so valid is not held back
    task automatic push(input int n, input logic [7:0] d0, input logic [2:0] f);
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk);
            rx_vld <= 1'b1;
            rx_chr <= {f, d0 + 8'(i)};
        end
        @(posedge i_clk);
        rx_vld <= 1'b0;
        rx_chr <= ~rx_chr;
        wait_n(4);
    endtask : push
    initial begin
        #2_000_000;
        error_cnt++;
        results();
    end
    initial begin
        repeat (16) @(posedge i_clk);
        i_srst <= 1'b0;
        wait_n(1);
        chk(16'({irq, txd, rx_rdy, receive_ready_pin_n, transmit_ready_pin_n, tx_lvl}), 16'h01c0);
        chk(div, 16'h0000);
        foreach (ROWS[i]) begin
            HOST.wr(ROWS[i][21:19], ROWS[i][18:11]);
            rchk(ROWS[i][10:8], ROWS[i][7:0]);
        end
        for (int w = 0; w < 4; w++) begin
            HOST.wr(uif_pkg::A_LCR, 8'(w) | 8'h04);
            wait_n(2);
            chk(16'({fmt.wl, fmt.stop_half}),
                16'({2'(w), w == 0 ? uif_pkg::HALF_15 : uif_pkg::HALF_2}));
        end
        for (int k = 0; k < 4; k++) begin
            HOST.wr(uif_pkg::A_LCR, 8'h08 | 8'(k << 4));
            wait_n(2);
            chk(16'({fmt.par_en, fmt.par_even, fmt.par_force}),
                16'({1'b1, k[0], k[1]}));
            if (k[1]) chk(16'(fmt.par_val), 16'(!k[0]));
        end
        HOST.wr(uif_pkg::A_LCR, 8'h40);
        wait_n(2);
        chk(16'({txd, fmt.brk}), 16'h0001);
        HOST.wr(uif_pkg::A_LCR, 8'h83);
        HOST.wr(uif_pkg::A_DATA, 8'h34);
        HOST.wr(uif_pkg::A_IER, 8'h12);
        wait_n(2);
        chk(div, 16'h1234);
        chk(16'(txd), 16'h0001);
        // break off: the serial output must follow the transmitter again
        @(posedge i_clk);
        ser_raw <= 1'b0;
        wait_n(2);
        chk(16'(txd), 16'h0000);
        @(posedge i_clk);
        ser_raw <= 1'b1;
        rchk(uif_pkg::A_IER, 8'h12);
        HOST.wr(uif_pkg::A_LCR, 8'h03);
        HOST.wr(uif_pkg::A_ISR, 8'h41);
        HOST.wr(uif_pkg::A_IER, 8'h01);
        push(3, 8'h10, 3'h0);
        rchk(uif_pkg::A_ISR, 8'hc1);
        chk(16'(receive_ready_pin_n), 16'h0000);
        rchk(uif_pkg::A_LSR, 8'h61);
        push(1, 8'h13, 3'h0);
        rchk(uif_pkg::A_ISR, 8'hc4);
        chk(16'(irq), 16'h0001);
        rchk(uif_pkg::A_DATA, 8'h10);
        rchk(uif_pkg::A_ISR, 8'hc1);
        // 8 data bits, 1 stop: 52 ticks to fire, 60 given
        @(posedge i_clk);
        tick <= 1'b1;
        repeat (60) @(posedge i_clk);
        tick <= 1'b0;
        rchk(uif_pkg::A_ISR, 8'hcc);
        rchk(uif_pkg::A_DATA, 8'h11);
        rchk(uif_pkg::A_ISR, 8'hc1);
        HOST.wr(uif_pkg::A_ISR, 8'h49);
        wait_n(2);
        chk(16'(receive_ready_pin_n), 16'h0001);
        HOST.wr(uif_pkg::A_ISR, 8'h43);
        rchk(uif_pkg::A_LSR, 8'h60);
        HOST.wr(uif_pkg::A_IER, 8'h05);
        push(22, 8'h00, 3'h0);
        chk(16'(rx_rdy), 16'h0000);
        rchk(uif_pkg::A_ISR, 8'hc6);
        rchk(uif_pkg::A_LSR, 8'h63);
        rchk(uif_pkg::A_ISR, 8'hc4);
        for (int i = 0; i < 18; i++) rchk(uif_pkg::A_DATA, 8'(i));
        rchk(uif_pkg::A_LSR, 8'h60);
        // parity-error char reaching the head raises the line interrupt
        push(1, 8'h77, 3'h1);
        rchk(uif_pkg::A_ISR, 8'hc6);
        rchk(uif_pkg::A_LSR, 8'he5);
        rchk(uif_pkg::A_DATA, 8'h77);
        HOST.wr(uif_pkg::A_IER, 8'h02);
        wait_n(2);
        chk(16'(irq), 16'h0001);
        repeat (3) HOST.wr(uif_pkg::A_DATA, 8'h55);
        wait_n(1);
        chk(16'(tx_lvl), 16'h0003);
        chk(16'(transmit_ready_pin_n), 16'h0001);
        rchk(uif_pkg::A_ISR, 8'hc1);
        rchk(uif_pkg::A_LSR, 8'h00);
        repeat (3) begin
            @(posedge i_clk);
            take <= 1'b1;
            @(posedge i_clk);
            take <= 1'b0;
        end
        rchk(uif_pkg::A_ISR, 8'hc2);
        repeat (2) HOST.wr(uif_pkg::A_DATA, 8'haa);
        HOST.wr(uif_pkg::A_ISR, 8'h45);
        wait_n(2);
        chk(16'(tx_lvl), 16'h0000);
        // queue empty but shifter busy: only bit 5 may be set
        @(posedge i_clk);
        shift_idle <= 1'b0;
        rchk(uif_pkg::A_LSR, 8'h20);
        @(posedge i_clk);
        shift_idle <= 1'b1;
        HOST.wr(uif_pkg::A_IER, 8'h08);
        @(posedge i_clk);
        modem_status <= 8'h01;
        rchk(uif_pkg::A_ISR, 8'hc0);
        rchk(uif_pkg::A_MSR, 8'h01);
        chk(16'(msr_rd), 16'h0001);
        @(posedge i_clk);
        modem_status <= 8'h00;
        HOST.wr(uif_pkg::A_IER, 8'h00);
        rchk(uif_pkg::A_ISR, 8'hc1);
        // fifos off: one held char is enough for the receive interrupt
        HOST.wr(uif_pkg::A_ISR, 8'h00);
        HOST.wr(uif_pkg::A_IER, 8'h01);
        push(1, 8'h5a, 3'h0);
        rchk(uif_pkg::A_ISR, 8'h04);
        rchk(uif_pkg::A_DATA, 8'h5a);
        @(posedge i_clk);
        i_srst <= 1'b1;
        @(posedge i_clk);
        i_srst <= 1'b0;
        rchk(uif_pkg::A_LCR, 8'h00);
        rchk(uif_pkg::A_ISR, 8'h01);
        results();
    end
endmodule : test_uart_interrupt_fifo_line_control

// ### verification/uif_host.sv
/*
 uif_host: host cpu model driving the register bus.
 assumes one clock; each access is a one-cycle strobe.
*/
`timescale 1ns/1ps
module uif_host (
    // clock
    input  wire logic         i_clk,
    // register bus
    output uif_pkg::uif_bus_s o_bus,
    input  wire logic [7:0]   i_rdata
);
    initial o_bus = '0;
    // released data flips so a stale value is never mistaken for a write
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge i_clk);
        o_bus <= '{addr: a, rd: 1'b0, wr: 1'b1, wdata: v};
        @(posedge i_clk);
        o_bus <= '{addr: a, rd: 1'b0, wr: 1'b0, wdata: ~v};
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge i_clk);
        o_bus <= '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        @(posedge i_clk);
        o_bus.rd <= 1'b0;
        #1;
        v = i_rdata;
    endtask : rd
endmodule : uif_host
